// file: hw/rivm_pkg.sv
// Package with source indices, table constants and widths for the vector map
package rivm_pkg;
  localparam int PC_WIDTH = 12;
  localparam int SRC_COUNT = 25;
  localparam int SRC_IDX_WIDTH = 5;
  localparam logic [PC_WIDTH-1:0] RESET_WORD = 12'h000;
  localparam logic [PC_WIDTH-1:0] TABLE_FIRST = 12'h001;
  localparam logic [PC_WIDTH-1:0] BOOT_RESET_DEFAULT = 12'hC00;
  localparam logic FUSE_UNPROGRAMMED = 1'b1;
  localparam logic FUSE_PROGRAMMED = 1'b0;
  // Source index n (0..24) is vector number n+2, word n+1
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_EXT0 = 5'h00;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_EXT1 = 5'h01;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_PCG0 = 5'h02;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_PCG2 = 5'h04;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_WDOG = 5'h05;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_T2CMPA = 5'h06;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_T2OVF = 5'h08;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_T1CAPT = 5'h09;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_T1OVF = 5'h0C;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_T0CMPA = 5'h0D;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_T0OVF = 5'h0F;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_SPI = 5'h10;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_SERRX = 5'h11;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_SERTX = 5'h13;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_ADC = 5'h14;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_TWOWIRE = 5'h17;
  localparam logic [SRC_IDX_WIDTH-1:0] SRC_PMWRITE = 5'h18;
  typedef enum logic [1:0] {
    FETCH_NONE,
    FETCH_RESET,
    FETCH_IRQ
  } rivm_fetch_type;
endpackage

// file: hw/rivm_vector_map.sv
// Reset and interrupt vector address generator for the core fetch unit
// Contract
// - All reset causes share one vector, word zero or boot address
// - External requests zero/one at words 1, 2
// - Pin change groups 3-5, watchdog word 6
// - Timer two: compare A/B, overflow 7-9
// - Timer one: capture, compare A/B, overflow A-D
// - Timer zero: compare A/B, overflow E-10
// - SPI 11, serial receive/empty/transmit 12-14
// - ADC, data mem, comparator, two-wire, write 15-19
// - Programmed fuse starts reset at boot address
// - Vector-select adds boot section start to table
// - Fuse and select bit act independently
// - Fuse one unprogrammed, zero programmed
// - Vector fetched only on reset or enabled dispatch
`timescale 1ns/1ps
`default_nettype none
module rivm_vector_map
  import rivm_pkg::*;
#(
  parameter logic [rivm_pkg::PC_WIDTH-1:0] BOOT_RESET_ADDR =
    rivm_pkg::BOOT_RESET_DEFAULT
) (
  input  wire logic                              clk,            // Core clock
  input  wire logic                              rst_n,          // Async reset
  input  wire logic                              bootResetFuse,  // Fuse, 0=prog
  input  wire logic                              vectorTableSelectBit, // Table
  input  wire logic                              dispatchReq,    // Irq taken
  input  wire logic [rivm_pkg::SRC_IDX_WIDTH-1:0] dispatchSrc,   // Source 0..24
  output logic                                   fetchValid,     // Vector out
  output logic [rivm_pkg::PC_WIDTH-1:0]          fetchAddr,      // Vector word
  output var rivm_pkg::rivm_fetch_type           fetchKind       // Reset/irq
);
  import rivm_pkg::*;

  // Word offset of a peripheral source inside the table (vector no. minus 1)
  function automatic logic [PC_WIDTH-1:0] srcOffset(
    input logic [SRC_IDX_WIDTH-1:0] src
  );
    srcOffset = TABLE_FIRST + PC_WIDTH'(src);
  endfunction

  logic                  fuseLatched;
  logic                  fuseCaught;
  logic                  next_fuseLatched;
  logic                  next_fuseCaught;
  logic                  resetPending;
  logic                  next_resetPending;
  logic                  next_fetchValid;
  logic [PC_WIDTH-1:0]   next_fetchAddr;
  rivm_fetch_type        next_fetchKind;
  logic [PC_WIDTH-1:0]   resetAddr;
  logic [PC_WIDTH-1:0]   tableBase;
  logic                  srcLegal;

  // Reset address and table base, chosen independently
  always_comb begin
    resetAddr = (fuseLatched == FUSE_PROGRAMMED) ? BOOT_RESET_ADDR
                                                 : RESET_WORD;
    tableBase = vectorTableSelectBit ? BOOT_RESET_ADDR
                                     : '0;
    srcLegal = (dispatchSrc < SRC_IDX_WIDTH'(SRC_COUNT));
  end

  // Fuse is caught once after reset release; reset fetch follows it
  always_comb begin
    next_fuseCaught = 1'b1;
    next_fuseLatched = fuseCaught ? fuseLatched : bootResetFuse;
    next_resetPending = resetPending && !fuseCaught;
    next_fetchValid = 1'b0;
    next_fetchAddr = fetchAddr;
    next_fetchKind = FETCH_NONE;
    if (resetPending && fuseCaught) begin
      next_fetchValid = 1'b1;
      next_fetchAddr = resetAddr;
      next_fetchKind = FETCH_RESET;
      next_resetPending = 1'b0;
    end else if (!resetPending && dispatchReq && srcLegal) begin
      next_fetchValid = 1'b1;
      next_fetchAddr = PC_WIDTH'(tableBase + srcOffset(dispatchSrc));
      next_fetchKind = FETCH_IRQ;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fuseCaught <= 1'b0;
      fuseLatched <= FUSE_UNPROGRAMMED;
      resetPending <= 1'b1;
      fetchValid <= 1'b0;
      fetchAddr <= RESET_WORD;
      fetchKind <= FETCH_NONE;
    end else begin
      fuseCaught <= next_fuseCaught;
      fuseLatched <= next_fuseLatched;
      resetPending <= next_resetPending;
      fetchValid <= next_fetchValid;
      fetchAddr <= next_fetchAddr;
      fetchKind <= next_fetchKind;
    end
  end

  // Checks
  sequence s_irqReq;
    !resetPending && dispatchReq && srcLegal;
  endsequence

  property p_resetFirst;
    @(posedge clk) disable iff (!rst_n)
    $rose(fuseCaught) |=> fetchValid && fetchKind == FETCH_RESET;
  endproperty
  a_resetFirst: assert property (p_resetFirst)
    else $error("reset fetch missing");

  property p_resetAddr;
    @(posedge clk) disable iff (!rst_n)
    fetchKind == FETCH_RESET |-> fetchAddr ==
      ((fuseLatched == FUSE_PROGRAMMED) ? BOOT_RESET_ADDR : RESET_WORD);
  endproperty
  a_resetAddr: assert property (p_resetAddr)
    else $error("reset address wrong");

  property p_irqAddr;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq |=> fetchValid && fetchAddr == PC_WIDTH'(
      ($past(vectorTableSelectBit) ? BOOT_RESET_ADDR : '0) +
      TABLE_FIRST + PC_WIDTH'($past(dispatchSrc)));
  endproperty
  a_irqAddr: assert property (p_irqAddr)
    else $error("vector address wrong");

  property p_ext0;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_EXT0 && !vectorTableSelectBit)
      |=> fetchAddr == 12'h001;
  endproperty
  a_ext0: assert property (p_ext0)
    else $error("external zero vector wrong");

  property p_lastSlot;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_PMWRITE && vectorTableSelectBit)
      |=> fetchAddr == PC_WIDTH'(BOOT_RESET_ADDR + 12'h019);
  endproperty
  a_lastSlot: assert property (p_lastSlot)
    else $error("boot table last vector wrong");

  property p_noSpurious;
    @(posedge clk) disable iff (!rst_n)
    !(!resetPending && dispatchReq && srcLegal) &&
      !(resetPending && fuseCaught) |=> !fetchValid;
  endproperty
  a_noSpurious: assert property (p_noSpurious)
    else $error("fetch without cause");

  property p_independent;
    @(posedge clk) disable iff (!rst_n)
    fetchKind == FETCH_IRQ && fuseLatched == FUSE_PROGRAMMED &&
      !$past(vectorTableSelectBit) |-> fetchAddr < 12'h01A;
  endproperty
  a_independent: assert property (p_independent)
    else $error("table follows fuse");

  property p_singleReset;
    @(posedge clk) disable iff (!rst_n)
    fetchKind == FETCH_RESET |=> fetchKind != FETCH_RESET [*8];
  endproperty
  a_singleReset: assert property (p_singleReset)
    else $error("reset fetched twice");

  // Fixed slots in the base table, one check per peripheral group except data mem, comparator and write, two for timer one
  property p_pinGroup0;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_PCG0 && !vectorTableSelectBit)
      |=> fetchAddr == 12'h003;
  endproperty
  a_pinGroup0: assert property (p_pinGroup0)
    else $error("pin change zero vector wrong");

  property p_watchdog;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_WDOG && !vectorTableSelectBit)
      |=> fetchAddr == 12'h006;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog vector wrong");

  property p_timer2Ovf;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_T2OVF && !vectorTableSelectBit)
      |=> fetchAddr == 12'h009;
  endproperty
  a_timer2Ovf: assert property (p_timer2Ovf)
    else $error("timer two overflow vector wrong");

  property p_timer1Capt;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_T1CAPT && !vectorTableSelectBit)
      |=> fetchAddr == 12'h00A;
  endproperty
  a_timer1Capt: assert property (p_timer1Capt)
    else $error("timer one capture vector wrong");

  property p_timer1Ovf;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_T1OVF && !vectorTableSelectBit)
      |=> fetchAddr == 12'h00D;
  endproperty
  a_timer1Ovf: assert property (p_timer1Ovf)
    else $error("timer one overflow vector wrong");

  property p_timer0Ovf;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_T0OVF && !vectorTableSelectBit)
      |=> fetchAddr == 12'h010;
  endproperty
  a_timer0Ovf: assert property (p_timer0Ovf)
    else $error("timer zero overflow vector wrong");

  property p_spiDone;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_SPI && !vectorTableSelectBit)
      |=> fetchAddr == 12'h011;
  endproperty
  a_spiDone: assert property (p_spiDone)
    else $error("serial peripheral vector wrong");

  property p_serialTx;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_SERTX && !vectorTableSelectBit)
      |=> fetchAddr == 12'h014;
  endproperty
  a_serialTx: assert property (p_serialTx)
    else $error("serial transmit vector wrong");

  property p_adcDone;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_ADC && !vectorTableSelectBit)
      |=> fetchAddr == 12'h015;
  endproperty
  a_adcDone: assert property (p_adcDone)
    else $error("converter vector wrong");

  property p_twoWire;
    @(posedge clk) disable iff (!rst_n)
    s_irqReq ##0 (dispatchSrc == SRC_TWOWIRE && !vectorTableSelectBit)
      |=> fetchAddr == 12'h018;
  endproperty
  a_twoWire: assert property (p_twoWire)
    else $error("two-wire vector wrong");
endmodule
`default_nettype wire

// file: sim/rivm_req_model.sv
// Peripheral request side model that feeds dispatch pulses to the block
`timescale 1ns/1ps
`default_nettype none
module rivm_req_model (
  input  wire logic       clk,         // Core clock
  input  wire logic       reqIn,       // Request wanted by bench
  input  wire logic [4:0] srcIn,       // Source wanted by bench
  input  wire logic       selIn,       // Table select wanted by bench
  output logic            dispatchReq, // Pulse to block
  output logic [4:0]      dispatchSrc, // Source to block
  output logic            selBit       // Table select to block
);
  // Drive on falling edge; idle source toggles so no stale value lingers
  initial begin
    dispatchReq = 1'b0;
    dispatchSrc = 5'h00;
    selBit = 1'b0;
  end
  always @(negedge clk) begin
    dispatchReq <= reqIn;
    dispatchSrc <= reqIn ? srcIn : ~dispatchSrc;
    selBit <= selIn;
  end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the reset and interrupt vector map
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rivm_pkg::*;
  localparam logic [11:0] BOOT = BOOT_RESET_DEFAULT;
  logic           clk, rst_n, fuse, reqIn, selIn, dReq, sel, fValid, sl;
  logic [4:0]     srcIn, dSrc;
  logic [11:0]    fAddr;
  rivm_fetch_type fKind;
  logic [13:0]    expQ[$];
  logic [31:0]    seed = 32'h2AB54D4B;
  int             nMismatch, checkCount, cycles;
  rivm_vector_map #(.BOOT_RESET_ADDR(BOOT)) dut_u (.clk(clk), .rst_n(rst_n),
    .bootResetFuse(fuse), .vectorTableSelectBit(sel), .dispatchReq(dReq),
    .dispatchSrc(dSrc), .fetchValid(fValid), .fetchAddr(fAddr),
    .fetchKind(fKind));
  rivm_req_model req_u (.clk(clk), .reqIn(reqIn), .srcIn(srcIn),
    .selIn(selIn), .dispatchReq(dReq), .dispatchSrc(dSrc), .selBit(sel));
  // Clock generation
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Fixed-seed xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Compare one value against its expectation
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Closing report
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Output watcher takes the oldest note for each fetch pulse
  always @(negedge clk) begin
    if (rst_n === 1'b1) begin
      if (fValid === 1'b1 && expQ.size() == 0)
        check({fKind, fAddr}, 14'h3FFF);
      else if (fValid === 1'b1)
        check({fKind, fAddr}, expQ.pop_front());
      else
        check({fKind, 12'h000}, {FETCH_NONE, 12'h000});
    end
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      nMismatch++;
      wrap_up();
    end
  end
  // Four resets with both fuse levels, each followed by every source index
  initial begin
    rst_n = 1'b0;
    fuse = 1'b1;
    reqIn = 1'b0;
    selIn = 1'b0;
    srcIn = 5'h00;
    for (int m = 0; m < 4; m++) begin
      @(negedge clk);
      rst_n = 1'b0;
      fuse = m[0];
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      expQ.push_back({FETCH_RESET, fuse ? RESET_WORD : BOOT});
      @(posedge clk);
      for (int i = 0; i < 32; i++) begin
        @(posedge clk);
        sl = xs() > 32'h7FFFFFFF;
        reqIn <= 1'b1;
        srcIn <= 5'(i);
        selIn <= sl;
        if (i < 25)
          expQ.push_back({FETCH_IRQ, (sl ? BOOT : RESET_WORD) + TABLE_FIRST
            + 12'(i)});
      end
      @(posedge clk);
      reqIn <= 1'b0;
      repeat (4) @(posedge clk);
      check(14'(expQ.size()), 14'h0000);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
